// [rtl/fan_cfg_pkg.sv]
// Summary of operation
// - direct-write clear: level from temp and table; both read-only
// - direct-write set: level and table writable; level drives output
// - sense bit 0: pull low for off; sense bit 1: pull low for on
// - base clock choice bit selects 360 kHz when clear, 1.4 kHz when set
// - bits 7:6 of both config registers always read zero
// - mode 00 plain counting; mode 01 reports FFFF below minimum speed
// - modes 10 and 11 gate speed sensing by drive; FFFF below minimum
// - with 360 kHz base clock the speed-sense mode behaves as 00
// - speed-terminated kick clear: kick uses programmed level and duration
// - speed-terminated kick: full drive until time out or target speed
// - speed-terminated kick overrides kick level; start-up drive full
// - kick duration 000 skips the kick regardless of speed-terminated bit
// - kick level: 00 none unless speed-terminated, 01 half, 10 ~3/4, 11 full
// - drive frequency is base clock over 2n, with n of zero taken as one
// - drive level register reads zero while the kick is running
package fan_cfg_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_TACH_LSB = 8'h46;
  localparam logic [7:0] ADDR_TACH_MSB = 8'h47;
  localparam logic [7:0] ADDR_LIM_LSB = 8'h48;
  localparam logic [7:0] ADDR_LIM_MSB = 8'h49;
  localparam logic [7:0] ADDR_SENSE_CFG = 8'h4A;
  localparam logic [7:0] ADDR_KICK_CFG = 8'h4B;
  localparam logic [7:0] ADDR_LEVEL = 8'h4C;
  localparam logic [7:0] ADDR_FREQ = 8'h4D;
  localparam logic [3:0] ADDR_LUT_HI = 4'h5;
  localparam logic [7:0] RST_SENSE_CFG = 8'h20;
  localparam logic [7:0] RST_KICK_CFG = 8'h3F;
  localparam logic [4:0] RST_FREQ = 5'h17;
  localparam logic [7:0] RST_LIM = 8'hFF;
  localparam logic [6:0] RST_LUT_TEMP = 7'h7F;
  localparam logic [5:0] RST_LUT_DUTY = 6'h3F;
  localparam int LUT_ENTRIES = 8;
  // ==========================================================
  // duty codes and modes
  localparam logic [5:0] DUTY_FULL = 6'h3F;
  localparam logic [5:0] DUTY_HALF = 6'h20;
  localparam logic [5:0] DUTY_3Q = 6'h30;
  localparam logic [5:0] DUTY_OFF = 6'h00;
  localparam logic [1:0] KICK_NONE = 2'h0;
  localparam logic [1:0] KICK_HALF = 2'h1;
  localparam logic [1:0] KICK_3Q = 2'h2;
  localparam logic [1:0] MODE_PLAIN = 2'h0;
  localparam logic [15:0] TACH_SAT = 16'hFFFF;
  // ==========================================================
  // timing
  localparam int unsigned REF_CLK_HZ = 40_000_000;
  localparam int unsigned BASE_FAST_HZ = 360_000;
  localparam int unsigned BASE_SLOW_HZ = 1_400;
  localparam int unsigned TACH_TICK_HZ = 90_000;
  localparam int unsigned KICK_STEP_US = 50_000;
  localparam int unsigned FAST_DIV_CYCLES = REF_CLK_HZ / BASE_FAST_HZ;
  localparam int unsigned SLOW_DIV_CYCLES = REF_CLK_HZ / BASE_SLOW_HZ;
  localparam int unsigned TACH_DIV_CYCLES = REF_CLK_HZ / TACH_TICK_HZ;
  localparam int unsigned KICK_STEP_CYCLES =
    (REF_CLK_HZ / 1_000_000) * KICK_STEP_US;

  typedef struct packed {
    logic [1:0] unused;
    logic direct;
    logic sense;
    logic slow_clk;
    logic rsvd;
    logic [1:0] mode;
  } sense_cfg_t;

  typedef struct packed {
    logic [1:0] unused;
    logic fast;
    logic [1:0] level;
    logic [2:0] time_sel;
  } kick_cfg_t;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_KICK = 2'b01,
    ST_RUN = 2'b10
  } kick_state_t;
endpackage

// [rtl/fan_drive_tach_config.sv]
`timescale 1ns/10ps
`default_nettype none
module fan_drive_tach_config
  import fan_cfg_pkg::*;
#(
  parameter int unsigned SLOW_DIV = SLOW_DIV_CYCLES,
  parameter int unsigned KICK_STEP = KICK_STEP_CYCLES
) (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RESET_I,
  // register port from the serial front end
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  // temperature from the measurement path
  input wire logic [7:0] REMOTE_TEMP_I,
  // fan pins
  input wire logic TACH_I,
  output logic FAN_DRV_O,
  output logic FAN_DRV_OE_N_O,
  // status
  output logic [1:0] TACH_MODE_O,
  output logic KICK_ACTIVE_O
);
  // ==========================================================
  // configuration registers
  sense_cfg_t sense_cfg, next_sense_cfg;
  kick_cfg_t kick_cfg, next_kick_cfg;
  logic [4:0] freq, next_freq;
  logic [5:0] level, next_level;
  logic [7:0] lim_lsb, next_lim_lsb, lim_msb, next_lim_msb;
  logic [6:0] lut_temp [LUT_ENTRIES];
  logic [5:0] lut_duty [LUT_ENTRIES];
  logic [6:0] next_lut_temp [LUT_ENTRIES];
  logic [5:0] next_lut_duty [LUT_ENTRIES];
  logic wr_lut;
  logic [2:0] lut_idx;

  assign wr_lut = REG_WR_I && (REG_ADDR_I[7:4] == ADDR_LUT_HI);
  assign lut_idx = REG_ADDR_I[3:1];

  always_comb begin
    next_sense_cfg = sense_cfg;
    next_kick_cfg = kick_cfg;
    next_freq = freq;
    next_level = level;
    next_lim_lsb = lim_lsb;
    next_lim_msb = lim_msb;
    if (REG_WR_I) begin
      case (REG_ADDR_I)
        ADDR_SENSE_CFG: begin
          // upper bits never stored
          next_sense_cfg = sense_cfg_t'({2'b00, REG_WDATA_I[5:0]});
        end
        ADDR_KICK_CFG: begin
          next_kick_cfg = kick_cfg_t'({2'b00, REG_WDATA_I[5:0]});
        end
        ADDR_FREQ: next_freq = REG_WDATA_I[4:0];
        ADDR_LIM_LSB: next_lim_lsb = REG_WDATA_I;
        ADDR_LIM_MSB: next_lim_msb = REG_WDATA_I;
        ADDR_LEVEL: begin
          if (sense_cfg.direct) begin
            next_level = REG_WDATA_I[5:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sense_cfg <= sense_cfg_t'(RST_SENSE_CFG);
      kick_cfg <= kick_cfg_t'(RST_KICK_CFG);
      freq <= RST_FREQ;
      level <= DUTY_OFF;
      lim_lsb <= RST_LIM;
      lim_msb <= RST_LIM;
    end else begin
      sense_cfg <= next_sense_cfg;
      kick_cfg <= next_kick_cfg;
      freq <= next_freq;
      level <= next_level;
      lim_lsb <= next_lim_lsb;
      lim_msb <= next_lim_msb;
    end
  end

  // ==========================================================
  // temperature-to-drive table
  logic [LUT_ENTRIES-1:0] exceed;
  logic [5:0] table_duty;

  for (genvar i = 0; i < LUT_ENTRIES; i++) begin : g_lut
    always_comb begin
      next_lut_temp[i] = lut_temp[i];
      next_lut_duty[i] = lut_duty[i];
      // table only writable in direct mode
      if (wr_lut && sense_cfg.direct && lut_idx == 3'(i)) begin
        if (REG_ADDR_I[0]) begin
          next_lut_duty[i] = REG_WDATA_I[5:0];
        end else begin
          next_lut_temp[i] = REG_WDATA_I[6:0];
        end
      end
    end
    always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
        lut_temp[i] <= RST_LUT_TEMP;
        lut_duty[i] <= RST_LUT_DUTY;
      end else begin
        lut_temp[i] <= next_lut_temp[i];
        lut_duty[i] <= next_lut_duty[i];
      end
    end
    assign exceed[i] = REMOTE_TEMP_I > {1'b0, lut_temp[i]};
  end

  // highest exceeded entry wins; below every entry the fan is off
  always_comb begin
    table_duty = DUTY_OFF;
    for (int k = 0; k < LUT_ENTRIES; k++) begin
      if (exceed[k]) begin
        table_duty = lut_duty[k];
      end
    end
  end

  // ==========================================================
  // tachometer
  logic tach_s1, tach_s2, tach_d;
  logic [8:0] tdiv, next_tdiv;
  logic [15:0] tcnt, next_tcnt, tach_count, next_tach_count;
  logic tach_fresh, next_tach_fresh;
  logic [1:0] eff_mode;
  logic tach_rise, tach_tick, tach_sat, gate;
  logic drv_on;

  always_comb begin
    eff_mode = sense_cfg.slow_clk ? sense_cfg.mode : MODE_PLAIN;
    // gated modes only count while the drive powers the fan
    gate = !eff_mode[1] || drv_on;
    tach_rise = tach_s2 && !tach_d;
    tach_tick = (tdiv >= 9'(TACH_DIV_CYCLES - 1));
    tach_sat = (tcnt == TACH_SAT);
    next_tdiv = tach_tick ? 9'h000 : 9'(tdiv + 9'h001);
    next_tcnt = tcnt;
    next_tach_count = tach_count;
    next_tach_fresh = 1'b0;
    if (tach_rise) begin
      next_tcnt = 16'h0000;
      next_tach_count = tcnt;
      next_tach_fresh = 1'b1;
    end else if (tach_tick && gate && !tach_sat) begin
      next_tcnt = 16'(tcnt + 16'h0001);
    end
    // stalled fan: mode 00 keeps its stale reading by design
    if (tach_sat && !tach_rise && eff_mode != MODE_PLAIN) begin
      next_tach_count = TACH_SAT;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      // pin idles high: a low reset here would fake an edge
      tach_s1 <= 1'b1;
      tach_s2 <= 1'b1;
      tach_d <= 1'b1;
      tdiv <= 9'h000;
      tcnt <= 16'h0000;
      tach_count <= TACH_SAT;
      tach_fresh <= 1'b0;
    end else begin
      tach_s1 <= TACH_I;
      tach_s2 <= tach_s1;
      tach_d <= tach_s2;
      tdiv <= next_tdiv;
      tcnt <= next_tcnt;
      tach_count <= next_tach_count;
      tach_fresh <= next_tach_fresh;
    end
  end

  // ==========================================================
  // start-up kick
  kick_state_t state, next_state;
  logic [23:0] ktimer, next_ktimer;
  logic [5:0] target, kick_duty, drive_duty;
  logic bypass, reached;

  always_comb begin
    target = sense_cfg.direct ? level : table_duty;
    case (kick_cfg.level)
      KICK_HALF: kick_duty = DUTY_HALF;
      KICK_3Q: kick_duty = DUTY_3Q;
      default: kick_duty = DUTY_FULL;
    endcase
    if (kick_cfg.fast) begin
      kick_duty = DUTY_FULL;
    end
    bypass = (kick_cfg.time_sel == 3'h0) ||
      (kick_cfg.level == KICK_NONE && !kick_cfg.fast);
    // lower count means faster fan
    reached = tach_fresh && (tach_count <= {lim_msb, lim_lsb});
    next_state = state;
    next_ktimer = ktimer;
    case (state)
      ST_OFF: begin
        if (target != DUTY_OFF) begin
          next_state = bypass ? ST_RUN : ST_KICK;
          next_ktimer = 24'(kick_cfg.time_sel * KICK_STEP);
        end
      end
      ST_KICK: begin
        next_ktimer = 24'(ktimer - 24'h000001);
        if (ktimer <= 24'h000001 || (kick_cfg.fast && reached)) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (target == DUTY_OFF) begin
          next_state = ST_OFF;
        end
      end
      default: next_state = ST_OFF;
    endcase
    drive_duty = (state == ST_KICK) ? kick_duty : target;
  end

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state <= ST_OFF;
      ktimer <= 24'h000000;
    end else begin
      state <= next_state;
      ktimer <= next_ktimer;
    end
  end

  fan_pwm_gen #(
    .SLOW_DIV(SLOW_DIV)
  ) u_pwm (
    .clk_i(REF_CLK_I),
    .rst_i(RESET_I),
    .duty_i(drive_duty),
    .freq_i(freq),
    .slow_i(sense_cfg.slow_clk),
    .sense_i(sense_cfg.sense),
    .on_o(drv_on),
    .oe_n_o(FAN_DRV_OE_N_O)
  );

  // ==========================================================
  // read path and status outputs
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    if (REG_ADDR_I[7:4] == ADDR_LUT_HI) begin
      next_rdata = REG_ADDR_I[0] ? {2'b00, lut_duty[lut_idx]} :
        {1'b0, lut_temp[lut_idx]};
    end else begin
      case (REG_ADDR_I)
        ADDR_SENSE_CFG: next_rdata = {2'b00, sense_cfg[5:0]};
        ADDR_KICK_CFG: next_rdata = {2'b00, kick_cfg[5:0]};
        ADDR_FREQ: next_rdata = {3'b000, freq};
        ADDR_LIM_LSB: next_rdata = lim_lsb;
        ADDR_LIM_MSB: next_rdata = lim_msb;
        ADDR_TACH_LSB: next_rdata = tach_count[7:0];
        ADDR_TACH_MSB: next_rdata = tach_count[15:8];
        ADDR_LEVEL: begin
          next_rdata = (state == ST_KICK) ? 8'h00 :
            {2'b00, target};
        end
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      REG_RDATA_O <= 8'h00;
      REG_RVALID_O <= 1'b0;
      TACH_MODE_O <= MODE_PLAIN;
      KICK_ACTIVE_O <= 1'b0;
      FAN_DRV_O <= 1'b0;
    end else begin
      REG_RDATA_O <= REG_RD_I ? next_rdata : 8'h00;
      REG_RVALID_O <= REG_RD_I;
      TACH_MODE_O <= eff_mode;
      KICK_ACTIVE_O <= (next_state == ST_KICK);
      FAN_DRV_O <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);

  a_kick_reads_zero: assert property (
    REG_RD_I && REG_ADDR_I == ADDR_LEVEL && state == ST_KICK
    |=> REG_RDATA_O == 8'h00 && REG_RVALID_O)
    else $error("level register not zero during kick");
  a_unused_bits_zero: assert property (
    REG_RD_I && (REG_ADDR_I == ADDR_SENSE_CFG ||
    REG_ADDR_I == ADDR_KICK_CFG) |=> REG_RDATA_O[7:6] == 2'b00)
    else $error("unused config bits read nonzero");
  a_level_locked: assert property (
    REG_WR_I && REG_ADDR_I == ADDR_LEVEL && !sense_cfg.direct
    |=> $stable(level))
    else $error("level written while table driven");
  a_direct_write: assert property (
    REG_WR_I && REG_ADDR_I == ADDR_LEVEL && sense_cfg.direct
    |=> level == $past(REG_WDATA_I[5:0]))
    else $error("direct level write lost");
  a_fast_kick_full: assert property (
    state == ST_KICK && kick_cfg.fast |-> drive_duty == DUTY_FULL)
    else $error("speed-terminated kick not at full drive");
  a_kick_bypass: assert property (
    state == ST_OFF && target != DUTY_OFF && kick_cfg.time_sel == 3'h0
    |=> state == ST_RUN)
    else $error("kick not skipped with zero duration");
  a_fast_clk_mode: assert property (
    !sense_cfg.slow_clk |=> TACH_MODE_O == MODE_PLAIN)
    else $error("fast base clock did not force plain mode");
  a_stall_reads_ones: assert property (
    tach_sat && !tach_rise && eff_mode != MODE_PLAIN
    |=> tach_count == TACH_SAT)
    else $error("stalled fan not reported as all ones");
  a_speed_ends_kick: assert property (
    state == ST_KICK && kick_cfg.fast && reached |=> state == ST_RUN)
    else $error("target speed did not end kick");

  c_kick_run: cover property (state == ST_KICK ##1 state == ST_RUN);
  c_fast_stop: cover property (state == ST_KICK && kick_cfg.fast && reached);
  c_direct_lvl: cover property (REG_WR_I && sense_cfg.direct &&
    REG_ADDR_I == ADDR_LEVEL);
  c_gated_mode: cover property (eff_mode[1] && tach_rise);
endmodule
`default_nettype wire

// [rtl/fan_pwm_gen.sv]
`timescale 1ns/10ps
`default_nettype none
module fan_pwm_gen
  import fan_cfg_pkg::*;
#(
  parameter int unsigned SLOW_DIV = SLOW_DIV_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic [5:0] duty_i,
  input wire logic [4:0] freq_i,
  input wire logic slow_i,
  input wire logic sense_i,
  // drive
  output logic on_o,
  output logic oe_n_o
);
  // ==========================================================
  // base clock and phase
  logic [14:0] div_cnt, next_div_cnt;
  logic [5:0] phase, next_phase;
  logic next_on, next_oe_n;
  logic [14:0] div_top;
  logic [5:0] two_n;
  logic tick;

  always_comb begin
    div_top = slow_i ? 15'(SLOW_DIV - 1) : 15'(FAST_DIV_CYCLES - 1);
    // n of zero counts as one
    two_n = (freq_i == 5'h00) ? 6'h02 : {freq_i, 1'b0};
    tick = (div_cnt >= div_top);
    next_div_cnt = tick ? 15'h0000 : 15'(div_cnt + 15'h0001);
    next_phase = phase;
    if (tick) begin
      next_phase = (phase >= 6'(two_n - 6'h01)) ? 6'h00 :
        6'(phase + 6'h01);
    end
    // compare phase/2n against duty/63 without a divider
    next_on = (12'(phase) * 12'h03F) < (12'(duty_i) * 12'(two_n));
    next_oe_n = next_on ^ sense_i;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt <= 15'h0000;
      phase <= 6'h00;
      on_o <= 1'b0;
      oe_n_o <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      phase <= next_phase;
      on_o <= next_on;
      oe_n_o <= next_oe_n;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_drive_polarity: assert property (
    ##1 (on_o ^ oe_n_o) == $past(sense_i))
    else $error("drive pin polarity does not follow sense bit");
  a_zero_freq_one: assert property (
    (freq_i == 5'h00) && tick |=> phase <= 6'h01)
    else $error("frequency field zero not treated as one");
endmodule
`default_nettype wire

// [testbench/fan_model.sv]
`timescale 1ns/10ps
`default_nettype none
module fan_model #(
  parameter int HALF = 15
) (
  // clock
  input wire logic clk_i,
  // drive pin and spin control
  input wire logic drv_i,
  input wire logic oe_n_i,
  input wire logic spin_i,
  // tach return
  output logic tach_o
);
  // ==========================================================
  // tach pulses while spinning; a stopped fan leaves the pull-up high
  int cnt = 0;
  logic pin;
  logic tach_q = 1'b1;
  // sense 0 assumed: a released pin floats high and powers the fan
  assign pin = oe_n_i ? 1'b1 : drv_i;
  assign tach_o = tach_q;
  always @(posedge clk_i) begin
    if (!spin_i) begin
      tach_q <= 1'b1;
      cnt <= 0;
    end else if (!pin) begin
      cnt <= cnt;
    end else if (cnt == HALF - 1) begin
      tach_q <= ~tach_q;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import fan_cfg_pkg::*;
  // short counts keep the run brief
  localparam int unsigned SDIV = 200;
  localparam int unsigned KSTEP = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] temp = 8'h00;
  logic spin = 1'b0;
  logic [7:0] rdata;
  logic rvalid, tach, drv, oe_n, kick;
  logic [1:0] mode;
  int bad_count = 0;
  int n_tests = 0;
  always #12.5 clk = ~clk;
  // ==========================================================
  // design and fan
  fan_drive_tach_config #(.SLOW_DIV(SDIV), .KICK_STEP(KSTEP))
    i_fan_drive_tach_config (
    .REF_CLK_I(clk), .RESET_I(rst), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
    .REMOTE_TEMP_I(temp), .TACH_I(tach), .FAN_DRV_O(drv),
    .FAN_DRV_OE_N_O(oe_n), .TACH_MODE_O(mode),
    .KICK_ACTIVE_O(kick));
  fan_model i_fan_model (.clk_i(clk), .drv_i(drv), .oe_n_i(oe_n),
    .spin_i(spin), .tach_o(tach));
  // ==========================================================
  // helpers
  task automatic final_report();
    if (bad_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge clk) #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    tick();
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick();
    wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    tick();
    addr = a;
    rd = 1'b1;
    tick();
    rd = 1'b0;
    chk({7'h00, rvalid, rdata}, {8'h01, e});
  endtask
  // bounded wait for the drive enable to reach a level
  task automatic wait_oe(input logic v, inout int p);
    int i;
    for (i = 0; i < 9000 && oe_n !== v; i++) begin
      tick();
      p++;
    end
    if (oe_n !== v) begin
      bad_count++;
      final_report();
    end
  endtask
  function automatic logic [7:0] exp_duty(input logic [7:0] r);
    return r > 8'h40 ? 8'h0A : (r > 8'h20 ? 8'h05 : 8'h00);
  endfunction
  // ==========================================================
  // main sequence
  int nv[3] = '{0, 3, 2};
  logic [7:0] kc[6] = '{8'h0A, 8'h03, 8'h23, 8'h20, 8'h27, 8'h11};
  int ke[6] = '{2 * KSTEP, 0, 3 * KSTEP, 0, -1, KSTEP};
  initial begin
    int p, i, t, n;
    logic [7:0] d;
    void'($urandom(80));
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    rd_chk(ADDR_SENSE_CFG, 8'h20);
    rd_chk(ADDR_KICK_CFG, 8'h3F);
    rd_chk(ADDR_LEVEL, 8'h00);
    rd_chk(8'h4E, 8'h00);
    rd_chk(ADDR_TACH_LSB, 8'hFF);
    rd_chk(ADDR_TACH_MSB, 8'hFF);
    // every mode under both base clocks, random upper bits
    for (i = 0; i < 8; i++) begin
      d = 8'($urandom());
      d = {d[7:4], i[2], 1'b0, i[1:0]};
      wr_reg(ADDR_SENSE_CFG, d);
      rd_chk(ADDR_SENSE_CFG, d & 8'h3F);
      chk(16'(mode), 16'(i[2] ? i[1:0] : 2'b00));
      d = 8'($urandom());
      wr_reg(ADDR_KICK_CFG, d);
      rd_chk(ADDR_KICK_CFG, d & 8'h3F);
    end
    // table load, then table-driven level
    wr_reg(ADDR_KICK_CFG, 8'h00);
    wr_reg(ADDR_SENSE_CFG, 8'h20);
    wr_reg(8'h50, 8'h20);
    wr_reg(8'h51, 8'h05);
    wr_reg(8'h52, 8'h40);
    wr_reg(8'h53, 8'h0A);
    wr_reg(ADDR_SENSE_CFG, 8'h00);
    wr_reg(8'h52, 8'h00);
    wr_reg(ADDR_LEVEL, 8'h15);
    for (i = 0; i < 8; i++) begin
      temp = (i < 2) ? 8'(8'h20 + i * 8'h20) : 8'($urandom_range(126));
      repeat (3) tick();
      rd_chk(ADDR_LEVEL, exp_duty(temp));
    end
    // drive sense against fan on and off; no kick with time 000
    for (i = 0; i < 4; i++) begin
      wr_reg(ADDR_SENSE_CFG, {3'b001, i[1], 4'h0});
      wr_reg(ADDR_LEVEL, i[0] ? 8'h3F : 8'h00);
      rd_chk(ADDR_LEVEL, i[0] ? 8'h3F : 8'h00);
      repeat (400) tick();
      chk(16'({drv, oe_n, kick}), 16'({1'b0, i[0] ^ i[1], 1'b0}));
    end
    // drive period from base clock and frequency field
    wr_reg(ADDR_LEVEL, 8'h10);
    for (i = 0; i < 3; i++) begin
      wr_reg(ADDR_SENSE_CFG, i < 2 ? 8'h28 : 8'h20);
      wr_reg(ADDR_FREQ, 8'(nv[i]));
      n = nv[i] == 0 ? 1 : nv[i];
      for (t = 0; t < 2; t++) begin
        wait_oe(1'b0, p);
        wait_oe(1'b1, p);
      end
      p = 0;
      wait_oe(1'b0, p);
      wait_oe(1'b1, p);
      chk(16'(p), 16'(2 * n * (i < 2 ? SDIV : FAST_DIV_CYCLES)));
    end
    // start-up kick cases; the fifth one ends on tach speed
    for (i = 0; i < 6; i++) begin
      spin = (i == 4);
      wr_reg(ADDR_LEVEL, 8'h00);
      wr_reg(ADDR_KICK_CFG, kc[i]);
      wr_reg(ADDR_LEVEL, 8'h10);
      p = 0;
      for (t = 0; t < 300; t++) begin
        tick();
        p += int'(kick === 1'b1);
        if (t == 9) begin
          addr = ADDR_LEVEL;
          rd = 1'b1;
        end
        if (t == 10) begin
          rd = 1'b0;
          if (kick === 1'b1) chk(16'(rdata), 16'h0000);
        end
      end
      if (ke[i] < 0) begin
        chk(16'(p > 0 && p < 7 * KSTEP), 16'h0001);
      end else begin
        chk(16'(p), 16'(ke[i]));
      end
    end
    final_report();
  end
endmodule
`default_nettype wire
